// *** shared/bfc_pkg.sv ***
package bfc_pkg;
  localparam int WORD_W    = 26;
  localparam int ADDR_W    = 15;
  localparam int IND_BIT   = 25;
  localparam int IDX_HI    = 24;
  localparam int IDX_LO    = 21;
  localparam int OP_HI     = 20;
  localparam int OP_LO     = 15;
  localparam int SEL_HI    = 14;
  localparam int SEL_LO    = 11;
  localparam int M_HI      = 10;
  localparam int M_LO      = 1;
  localparam int LINK_LO   = 1;
  localparam int LINK_HI   = 15;
  localparam int CLR_LO    = 16;
  localparam int CLR_HI    = 25;
  localparam int NUM_SENSE = 8;
  localparam int NUM_CHAN  = 13;
  localparam logic [5:0] BRANCH_COND_OP   = 6'h30;
  localparam logic [5:0] CLEAR_FLAG_OP    = 6'h31;
  localparam logic [5:0] SET_FLAG_OP      = 6'h32;
  localparam logic [5:0] JUMP_ALWAYS_OP   = 6'h06;
  localparam logic [5:0] BRANCH_LINK_OP   = 6'h07;
  localparam logic [3:0] SEL_EQUAL        = 4'h6;
  localparam logic [3:0] SEL_HIGH         = 4'h7;
  localparam logic [3:0] SEL_LOW          = 4'h5;
  localparam logic [3:0] SEL_AR1          = 4'h1;
  localparam logic [3:0] SEL_AR4          = 4'h4;
  localparam logic [3:0] SEL_SENSE1       = 4'h8;
  localparam logic [3:0] SEL_LINK_PC      = 4'h1;
  localparam logic [3:0] SEL_LINK_MAR     = 4'h2;
  localparam logic [3:0] SEL_LINK_CHAN0   = 4'h3;
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  typedef enum logic [1:0] {BFC_IDLE, BFC_WAIT, BFC_STORE, BFC_LOAD} bfc_state_e;
endpackage

// *** core/bfc_sense_flags.sv ***
`timescale 1ns/1ps
module bfc_sense_flags #(
  parameter int N = bfc_pkg::NUM_SENSE
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  // commands
  input  wire logic         set_en,
  input  wire logic         clr_en,
  input  wire logic [2:0]   sel,
  // state
  output logic [N-1:0]      flags
);
  wire logic [N-1:0] sel_mask = N'(1) << sel;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flags <= '0;
    end else if (set_en) begin
      flags <= flags | sel_mask;
    end else if (clr_en) begin
      flags <= flags & ~sel_mask;
    end
  end

  a_set_sticks: assert property (@(posedge clock) disable iff (!resetn)
    set_en |=> flags[$past(sel)]) else $error("sense flag not set");
  a_clr_sticks: assert property (@(posedge clock) disable iff (!resetn)
    (clr_en && !set_en) |=> !flags[$past(sel)]) else $error("sense flag not cleared");
endmodule

// *** core/bfc_branch_flag_ctrl.sv ***
`timescale 1ns/1ps
module bfc_branch_flag_ctrl #(
  parameter int NUM_IDX = 16
) (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        resetn,
  // instruction issue
  input  wire logic                        instr_valid,
  input  wire logic [bfc_pkg::WORD_W-1:0]  instr_word,
  output logic                             instr_ready,
  output logic                             instr_done,
  // program counter
  input  wire logic [bfc_pkg::ADDR_W-1:0]  program_counter,
  output logic                             pc_load,
  output logic [bfc_pkg::ADDR_W-1:0]       pc_value,
  // counters and index registers
  input  wire logic [bfc_pkg::ADDR_W-1:0]  mem_addr_reg,
  input  wire logic [bfc_pkg::NUM_CHAN*bfc_pkg::ADDR_W-1:0] channel_address_counter,
  input  wire logic [NUM_IDX*bfc_pkg::ADDR_W-1:0] index_regs,
  // memory write of the return word
  output logic                             mem_we,
  output logic [bfc_pkg::ADDR_W-1:0]       mem_addr,
  output logic [bfc_pkg::WORD_W-1:0]       mem_wdata,
  // arithmetic unit flags
  input  wire logic                        cmp_valid,
  input  wire logic                        cmp_high,
  input  wire logic                        cmp_low,
  input  wire logic                        addsub_valid,
  input  wire logic                        addsub_zero,
  input  wire logic [3:0]                  ar_sign_neg,
  // flag state
  output logic                             equal_flag,
  output logic                             high_flag,
  output logic                             low_flag,
  output logic [bfc_pkg::NUM_SENSE-1:0]    sense_flags
);
  // =====================================================================
  // decode
  wire logic [3:0] idx_f = instr_word[bfc_pkg::IDX_HI:bfc_pkg::IDX_LO];
  wire logic [5:0] op_f  = instr_word[bfc_pkg::OP_HI:bfc_pkg::OP_LO];
  wire logic [3:0] sel_f = instr_word[bfc_pkg::SEL_HI:bfc_pkg::SEL_LO];
  wire logic [9:0] m_f   = instr_word[bfc_pkg::M_HI:bfc_pkg::M_LO];

  function automatic logic [bfc_pkg::ADDR_W-1:0] pick(
      input logic [bfc_pkg::NUM_CHAN*bfc_pkg::ADDR_W-1:0] v, input int i);
    pick = v[i*bfc_pkg::ADDR_W +: bfc_pkg::ADDR_W];
  endfunction

  // index zero means no modification
  wire logic [bfc_pkg::ADDR_W-1:0] idx_val =
    (idx_f == 4'h0) ? '0 : index_regs[idx_f*bfc_pkg::ADDR_W +: bfc_pkg::ADDR_W];
  wire logic [bfc_pkg::ADDR_W-1:0] eff_addr = bfc_pkg::ADDR_W'(m_f) + idx_val;

  wire logic is_cond  = op_f == bfc_pkg::BRANCH_COND_OP;
  wire logic is_jump  = op_f == bfc_pkg::JUMP_ALWAYS_OP;
  wire logic is_link  = op_f == bfc_pkg::BRANCH_LINK_OP;
  wire logic is_setf  = op_f == bfc_pkg::SET_FLAG_OP;
  wire logic is_clrf  = op_f == bfc_pkg::CLEAR_FLAG_OP;
  wire logic sel_sns  = sel_f >= bfc_pkg::SEL_SENSE1;
  wire logic sel_sign = sel_f >= bfc_pkg::SEL_AR1 && sel_f <= bfc_pkg::SEL_AR4;
  wire logic [1:0] ar_i = 2'(sel_f - bfc_pkg::SEL_AR1);

  // tested condition; reads only, never writes a flag
  wire logic cond_true =
    (sel_f == bfc_pkg::SEL_EQUAL) ? equal_flag :
    (sel_f == bfc_pkg::SEL_HIGH)  ? high_flag  :
    (sel_f == bfc_pkg::SEL_LOW)   ? low_flag   :
    sel_sign ? !ar_sign_neg[ar_i] :
    sel_sns  ? sense_flags[sel_f[2:0]] : 1'b0;

  // link source: pc, address register or one channel counter
  wire logic [bfc_pkg::ADDR_W-1:0] link_src =
    (sel_f == bfc_pkg::SEL_LINK_PC)  ? program_counter :
    (sel_f == bfc_pkg::SEL_LINK_MAR) ? mem_addr_reg :
    (sel_f >= bfc_pkg::SEL_LINK_CHAN0) ?
      pick(channel_address_counter, int'(sel_f - bfc_pkg::SEL_LINK_CHAN0)) : '0;

  // =====================================================================
  // sequencer
  bfc_pkg::bfc_state_e state;
  bfc_pkg::bfc_state_e next_state;
  logic [bfc_pkg::ADDR_W-1:0] held_addr;
  logic [1:0] cyc;

  wire logic start   = instr_valid && state == bfc_pkg::BFC_IDLE;
  wire logic take_now = start && (is_jump || (is_cond && cond_true));
  assign instr_ready = state == bfc_pkg::BFC_IDLE;

  always_comb begin
    next_state = state;
    case (state)
      bfc_pkg::BFC_IDLE: begin
        if (start && is_link) begin
          next_state = bfc_pkg::BFC_STORE;
        end else if (start && (is_setf || is_clrf || (is_cond && !cond_true))) begin
          next_state = bfc_pkg::BFC_WAIT;
        end
      end
      bfc_pkg::BFC_STORE: next_state = bfc_pkg::BFC_LOAD;
      bfc_pkg::BFC_LOAD:  next_state = bfc_pkg::BFC_IDLE;
      bfc_pkg::BFC_WAIT:  next_state = bfc_pkg::BFC_IDLE;
      default:            next_state = bfc_pkg::BFC_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state     <= bfc_pkg::BFC_IDLE;
      held_addr <= '0;
      cyc       <= '0;
      pc_load   <= 1'b0;
      pc_value  <= '0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
      instr_done <= 1'b0;
    end else begin
      state      <= next_state;
      pc_load    <= 1'b0;
      mem_we     <= 1'b0;
      instr_done <= 1'b0;
      cyc        <= (state == bfc_pkg::BFC_IDLE) ? 2'(start) : 2'(cyc + 2'h1);
      if (take_now) begin
        pc_load    <= 1'b1;
        pc_value   <= eff_addr;
        instr_done <= 1'b1;
      end else if (start && is_link) begin
        held_addr <= eff_addr;
        mem_we    <= 1'b1;
        mem_addr  <= eff_addr;
        mem_wdata <= {{(bfc_pkg::CLR_HI-bfc_pkg::CLR_LO+1){1'b0}},
                      link_src + bfc_pkg::ADDR_W'(1), 1'b0};
      end else if (state == bfc_pkg::BFC_WAIT) begin
        // untaken test advances sequentially; flag ops leave pc to sequencing
        instr_done <= 1'b1;
      end else if (state == bfc_pkg::BFC_LOAD) begin
        pc_load    <= 1'b1;
        pc_value   <= held_addr + bfc_pkg::ADDR_W'(1);
        instr_done <= 1'b1;
      end
    end
  end

  // =====================================================================
  // comparison flags: tests never write them
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      equal_flag <= 1'b0;
      high_flag  <= 1'b0;
      low_flag   <= 1'b0;
    end else if (cmp_valid) begin
      equal_flag <= !cmp_high && !cmp_low;
      high_flag  <= cmp_high;
      low_flag   <= !cmp_high && cmp_low;
    end else if (addsub_valid) begin
      equal_flag <= addsub_zero;
    end
  end

  // set/clear flags use only the select field; indirect, index and address ignored
  bfc_sense_flags #(.N(bfc_pkg::NUM_SENSE)) u_sense (
    .clock  (clock),
    .resetn (resetn),
    .set_en (start && is_setf && sel_sns),
    .clr_en (start && is_clrf && sel_sns),
    .sel    (sel_f[2:0]),
    .flags  (sense_flags)
  );

  // =====================================================================
  a_eq_taken: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_cond && sel_f == bfc_pkg::SEL_EQUAL && equal_flag) |=> (pc_load && pc_value == $past(eff_addr)))
    else $error("equal branch not taken");
  a_untaken_two: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_cond && !cond_true) |=> !pc_load && !instr_done ##1 instr_done && !pc_load)
    else $error("untaken test not two cycles");
  a_sign_pos: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_cond && sel_sign && !ar_sign_neg[ar_i]) |=> pc_load && instr_done)
    else $error("positive sign not one cycle");
  a_jump_one: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_jump) |=> (pc_load && instr_done && pc_value == $past(eff_addr)))
    else $error("jump not one cycle");
  a_link_seq: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_link) |=> mem_we ##1 !pc_load ##1 (pc_load && pc_value == mem_addr + 15'h1))
    else $error("link sequence wrong");
  a_link_zero: assert property (@(posedge clock) disable iff (!resetn)
    mem_we |-> mem_wdata[bfc_pkg::CLR_HI:bfc_pkg::CLR_LO] == '0)
    else $error("return word high bits not zero");
  a_test_keeps: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_cond && !cmp_valid && !addsub_valid) |=> $stable(equal_flag) && $stable(high_flag) && $stable(low_flag))
    else $error("test changed a flag");
  a_one_hot: assert property (@(posedge clock) disable iff (!resetn)
    $past(cmp_valid) |-> $onehot({equal_flag, high_flag, low_flag}))
    else $error("comparison flags not one-hot");
  a_flag_two: assert property (@(posedge clock) disable iff (!resetn)
    (start && (is_setf || is_clrf)) |=> !instr_done ##1 instr_done)
    else $error("flag op not two cycles");
  a_pc_free: assert property (@(posedge clock) disable iff (!resetn)
    (start && (is_setf || is_clrf)) |=> !pc_load [*2])
    else $error("flag op touched pc");

  // =====================================================================
  // cycle counts; cyc restarts at every accepted instruction, so it reads the length at done
  a_take_count: assert property (@(posedge clock) disable iff (!resetn)
    take_now |=> (instr_done && cyc == bfc_pkg::CYC_ONE))
    else $error("taken transfer not one cycle");

  a_wait_count: assert property (@(posedge clock) disable iff (!resetn)
    (state == bfc_pkg::BFC_WAIT) |=> (instr_done && cyc == bfc_pkg::CYC_TWO))
    else $error("two-cycle instruction miscounted");

  a_link_count: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_link) |=> ##2 (instr_done && cyc == bfc_pkg::CYC_THREE))
    else $error("link not three cycles");

  a_done_idle: assert property (@(posedge clock) disable iff (!resetn)
    instr_done |-> (state == bfc_pkg::BFC_IDLE))
    else $error("done while still busy");

  a_link_busy: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_link) |=> !instr_ready ##1 !instr_ready)
    else $error("link accepted a new instruction");

  a_flag_busy: assert property (@(posedge clock) disable iff (!resetn)
    (start && (is_setf || is_clrf)) |=> !instr_ready)
    else $error("flag op accepted a new instruction");

  // =====================================================================
  // transfer targets and tested conditions; the target is worked out from the raw fields
  a_target_direct: assert property (@(posedge clock) disable iff (!resetn)
    (take_now && idx_f == 4'h0) |=> (pc_value == bfc_pkg::ADDR_W'($past(m_f))))
    else $error("unindexed target wrong");

  a_target_indexed: assert property (@(posedge clock) disable iff (!resetn)
    (take_now && idx_f != 4'h0) |=>
      (pc_value == bfc_pkg::ADDR_W'($past(m_f)) + $past(index_regs[idx_f*bfc_pkg::ADDR_W +: bfc_pkg::ADDR_W])))
    else $error("indexed target wrong");

  a_high_taken: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_cond && sel_f == bfc_pkg::SEL_HIGH) |=> (pc_load == $past(high_flag)))
    else $error("high test wrong");

  a_low_taken: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_cond && sel_f == bfc_pkg::SEL_LOW) |=> (pc_load == $past(low_flag)))
    else $error("low test wrong");

  a_sign_neg: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_cond && sel_sign && ar_sign_neg[ar_i]) |=> (!pc_load && !instr_done))
    else $error("negative sign transferred");

  a_sense_test: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_cond && sel_sns) |=> (pc_load == $past(sense_flags[sel_f[2:0]])))
    else $error("sense test wrong");

  // =====================================================================
  // flag state; anything that is not a strobe or a flag op must leave the flags alone
  a_cmp_equal: assert property (@(posedge clock) disable iff (!resetn)
    cmp_valid |=> (equal_flag == !($past(cmp_high) || $past(cmp_low))))
    else $error("equal flag not from comparison");

  a_cmp_high: assert property (@(posedge clock) disable iff (!resetn)
    cmp_valid |=> (high_flag == $past(cmp_high)))
    else $error("high flag not from comparison");

  a_addsub_equal: assert property (@(posedge clock) disable iff (!resetn)
    (addsub_valid && !cmp_valid) |=> (equal_flag == $past(addsub_zero)))
    else $error("equal flag not from add or subtract");

  a_flags_idle: assert property (@(posedge clock) disable iff (!resetn)
    (!cmp_valid && !addsub_valid) |=> ($stable(equal_flag) && $stable(high_flag) && $stable(low_flag)))
    else $error("comparison flag changed without a strobe");

  a_sense_keep: assert property (@(posedge clock) disable iff (!resetn)
    !(start && (is_setf || is_clrf) && sel_sns) |=> $stable(sense_flags))
    else $error("sense flag changed without a flag op");

  a_set_pick: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_setf && sel_sns) |=> sense_flags[$past(sel_f[2:0])])
    else $error("wrong sense flag set");

  a_clear_pick: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_clrf && sel_sns) |=> !sense_flags[$past(sel_f[2:0])])
    else $error("wrong sense flag cleared");

  a_reset_clear: assert property (@(posedge clock)
    $rose(resetn) |-> (!equal_flag && !high_flag && !low_flag && sense_flags == '0))
    else $error("flags not clear after reset");

  // =====================================================================
  // return word sources
  a_link_pc: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_link && sel_f == bfc_pkg::SEL_LINK_PC) |=>
      (mem_wdata[bfc_pkg::LINK_HI:bfc_pkg::LINK_LO] == $past(program_counter) + bfc_pkg::ADDR_W'(1)))
    else $error("return word not counter plus one");

  a_link_mar: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_link && sel_f == bfc_pkg::SEL_LINK_MAR) |=>
      (mem_wdata[bfc_pkg::LINK_HI:bfc_pkg::LINK_LO] == $past(mem_addr_reg) + bfc_pkg::ADDR_W'(1)))
    else $error("return word not address register plus one");

  a_link_chan: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_link && sel_f >= bfc_pkg::SEL_LINK_CHAN0) |=>
      (mem_wdata[bfc_pkg::LINK_HI:bfc_pkg::LINK_LO] ==
       $past(pick(channel_address_counter, int'(sel_f - bfc_pkg::SEL_LINK_CHAN0))) + bfc_pkg::ADDR_W'(1)))
    else $error("return word not channel counter plus one");

  a_link_addr: assert property (@(posedge clock) disable iff (!resetn)
    (start && is_link) |=> (mem_addr == $past(eff_addr) && mem_wdata[bfc_pkg::LINK_LO-1] == 1'b0))
    else $error("return word address wrong");
endmodule

// *** tb/bfc_far_model.sv ***
`timescale 1ns/1ps
// ==========================================
// sequencing and memory side of the block
module bfc_far_model (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        resetn,
  // from the block
  input  wire logic                        pc_load,
  input  wire logic [bfc_pkg::ADDR_W-1:0]  pc_value,
  input  wire logic                        instr_done,
  input  wire logic                        mem_we,
  input  wire logic [bfc_pkg::ADDR_W-1:0]  mem_addr,
  input  wire logic [bfc_pkg::WORD_W-1:0]  mem_wdata,
  // sequencing and memory state
  output logic [bfc_pkg::ADDR_W-1:0]       pc,
  output logic [bfc_pkg::ADDR_W-1:0]       wr_addr,
  output logic [bfc_pkg::WORD_W-1:0]       wr_data
);
  // without a load the sequencer steps on by one at instr_done, as a real one does
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pc      <= 15'h0000;
      wr_addr <= 15'h0000;
      wr_data <= 26'h0000000;
    end else begin
      if (pc_load) begin
        pc <= pc_value;
      end else if (instr_done) begin
        pc <= pc + 15'h0001;
      end
      if (mem_we) begin
        wr_addr <= mem_addr;
        wr_data <= mem_wdata;
      end
    end
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic clock, resetn, instr_valid, instr_ready, instr_done, pc_load, mem_we;
  logic cmp_valid, cmp_high, cmp_low, addsub_valid, addsub_zero, eqf, hif, lof;
  logic [25:0] instr_word, mem_wdata, wr_data;
  logic [14:0] pc, pc_value, mar, mem_addr, wr_addr, pcx, src;
  logic [194:0] chans;
  logic [239:0] idx;
  logic [3:0]  ar_neg;
  logic [7:0]  sense, sx;
  logic [3:0]  cd [4];
  int          fails, n_checks;
  bfc_branch_flag_ctrl uut (.clock(clock), .resetn(resetn), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .instr_done(instr_done), .program_counter(pc), .pc_load(pc_load),
    .pc_value(pc_value), .mem_addr_reg(mar), .channel_address_counter(chans), .index_regs(idx),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .cmp_valid(cmp_valid), .cmp_high(cmp_high),
    .cmp_low(cmp_low), .addsub_valid(addsub_valid), .addsub_zero(addsub_zero), .ar_sign_neg(ar_neg),
    .equal_flag(eqf), .high_flag(hif), .low_flag(lof), .sense_flags(sense));
  bfc_far_model far (.clock(clock), .resetn(resetn), .pc_load(pc_load), .pc_value(pc_value),
    .instr_done(instr_done), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .pc(pc),
    .wr_addr(wr_addr), .wr_data(wr_data));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ==========================================
  // access tasks
  function automatic logic [25:0] mk(input logic [5:0] op, input logic [3:0] sel, input logic [3:0] x,
                                     input logic [9:0] m);
    mk = {1'b0, x, op, sel, m, 1'b0};
  endfunction
  task automatic test_done();
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [25:0] g, input logic [25:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // offer one instruction, count cycles to done, then look at the stepped counter
  task automatic run(input logic [25:0] w, input int ncyc, input logic [14:0] pc_exp);
    int n;
    n = 1;
    @(posedge clock);
    #1 instr_valid = 1'b1;
    instr_word = w;
    @(posedge clock);
    #1 instr_valid = 1'b0;
    chk(instr_ready, ncyc == 1);
    while (instr_done !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 20) begin
      fails++;
      test_done();
    end
    chk(n, ncyc);
    @(posedge clock);
    #1 chk(pc, pc_exp);
    pcx = pc_exp;
  endtask
  task automatic arith(input logic c, input logic h, input logic l, input logic z);
    @(posedge clock);
    #1 cmp_valid = c;
    addsub_valid = !c;
    cmp_high = h;
    cmp_low = l;
    addsub_zero = z;
    @(posedge clock);
    #1 cmp_valid = 1'b0;
    addsub_valid = 1'b0;
  endtask
  // ==========================================
  // sequence
  initial begin
    resetn = 1'b0; instr_valid = 1'b0; instr_word = 26'h0000000; mar = 15'h0ABC; ar_neg = 4'h5;
    cmp_valid = 1'b0; cmp_high = 1'b0; cmp_low = 1'b0; addsub_valid = 1'b0; addsub_zero = 1'b0;
    fails = 0; n_checks = 0; pcx = 15'h0000; idx = '0; idx[45 +: 15] = 15'h0100;
    cd = '{4'h1, 4'h2, 4'h3, 4'hF};
    for (int k = 0; k < 13; k++) chans[k*15 +: 15] = 15'h1000 + 15'(k);
    repeat (2) @(posedge clock);
    #1 resetn = 1'b1;
    chk({eqf, hif, lof, sense}, 11'h000);
    arith(1'b1, 1'b1, 1'b0, 1'b0);
    chk({eqf, hif, lof}, 3'h2);
    run(mk(bfc_pkg::BRANCH_COND_OP, bfc_pkg::SEL_EQUAL, 4'h0, 10'h020), 2, pcx + 15'h0001);
    run(mk(bfc_pkg::BRANCH_COND_OP, bfc_pkg::SEL_HIGH, 4'h3, 10'h020), 1, 15'h0120);
    chk({eqf, hif, lof}, 3'h2);
    arith(1'b1, 1'b0, 1'b1, 1'b0);
    run(mk(bfc_pkg::BRANCH_COND_OP, bfc_pkg::SEL_HIGH, 4'h0, 10'h020), 2, pcx + 15'h0001);
    run(mk(bfc_pkg::BRANCH_COND_OP, bfc_pkg::SEL_LOW, 4'h0, 10'h030), 1, 15'h0030);
    arith(1'b1, 1'b0, 1'b0, 1'b0);
    chk({eqf, hif, lof}, 3'h4);
    run(mk(bfc_pkg::BRANCH_COND_OP, bfc_pkg::SEL_EQUAL, 4'h0, 10'h050), 1, 15'h0050);
    arith(1'b0, 1'b0, 1'b0, 1'b0);
    chk(eqf, 1'b0);
    arith(1'b0, 1'b0, 1'b0, 1'b1);
    chk(eqf, 1'b1);
    // registers one and three are negative, two and four positive
    for (int k = 0; k < 4; k++) begin
      run(mk(bfc_pkg::BRANCH_COND_OP, 4'(k + 1), 4'h0, 10'h040 + 10'(k)), ar_neg[k] ? 2 : 1,
          ar_neg[k] ? pcx + 15'h0001 : 15'h0040 + 15'(k));
    end
    run(mk(bfc_pkg::JUMP_ALWAYS_OP, 4'hF, 4'h3, 10'h3FF), 1, 15'h04FF);
    for (int i = 0; i < 4; i++) begin
      src = (i == 0) ? pcx : (i == 1) ? mar : chans[(int'(cd[i]) - 3)*15 +: 15];
      run(mk(bfc_pkg::BRANCH_LINK_OP, cd[i], 4'h0, 10'h080), 3, 15'h0081);
      chk(wr_addr, 15'h0080);
      chk(wr_data, {10'h000, src + 15'h0001, 1'b0});
    end
    sx = 8'h00;
    for (int k = 0; k < 9; k++) begin
      sx[k % 8] = 1'b1;
      run(mk(bfc_pkg::SET_FLAG_OP, 4'h8 + 4'(k % 8), 4'h5, 10'h3FF), 2, pcx + 15'h0001);
      chk(sense, sx);
    end
    run(mk(bfc_pkg::BRANCH_COND_OP, 4'hA, 4'h0, 10'h060), 1, 15'h0060);
    for (int k = 0; k < 9; k++) begin
      sx[k % 8] = 1'b0;
      run(mk(bfc_pkg::CLEAR_FLAG_OP, 4'h8 + 4'(k % 8), 4'h3, 10'h155), 2, pcx + 15'h0001);
      chk(sense, sx);
    end
    run(mk(bfc_pkg::BRANCH_COND_OP, 4'hA, 4'h0, 10'h060), 2, pcx + 15'h0001);
    test_done();
  end
endmodule
